// ---- bench/rhci_checker.sv ----
/*
 port checker for the host command interpreter top.
 assumes one clock aclk and synchronous active-low aresetn.
*/
`timescale 1ns/1ps
`default_nettype none
`include "rhci_defs.vh"
module rhci_chk (
	// clock and reset
	input wire logic		aclk,
	input wire logic		aresetn,
	// register bus
	input wire logic		s_axi_awvalid,
	input wire logic		s_axi_awready,
	input wire logic		s_axi_wvalid,
	input wire logic		s_axi_wready,
	input wire logic		s_axi_bvalid,
	input wire logic		s_axi_bready,
	input wire logic		s_axi_arvalid,
	input wire logic		s_axi_arready,
	input wire logic		s_axi_rvalid,
	input wire logic		s_axi_rready,
	input wire logic [31:0]	s_axi_rdata,
	// command and result streams
	input wire logic		rx_valid,
	input wire logic		rx_ready,
	input wire logic [7:0]	rx_data,
	input wire logic		rx_last,
	input wire logic		tx_valid,
	input wire logic		tx_ready,
	input wire logic [7:0]	tx_data,
	// jumper, outputs, link
	input wire logic		interface_select,
	input wire logic [4:0]	gpio_out,
	input wire logic		spi_sclk,
	input wire logic		par_oe,
	input wire logic		par_strobe
);
	// *****
	// frame tracking
	// *****
	logic mid;
	always_ff @(posedge aclk)
		if (!aresetn) mid <= 1'b0;
		else if (rx_valid && rx_ready) mid <= !rx_last;
	default clocking @(posedge aclk); endclocking
	default disable iff (!aresetn);
	sequence s_one(logic [7:0] c);
		rx_valid && rx_ready && rx_last && !mid && rx_data == c;
	endsequence
	sequence s_both;
		s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready;
	endsequence
	// *****
	// checks
	// *****
	a_write_answer: assert property (s_both |-> ##2 s_axi_bvalid)
		else $error("write response missing");
	a_aw_blocked: assert property (s_axi_bvalid |-> !s_axi_awready)
		else $error("address taken during response");
	a_read_answer: assert property (s_axi_arvalid && s_axi_arready |=> s_axi_rvalid && !s_axi_arready)
		else $error("read response missing");
	a_rdata_hold: assert property (s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid && $stable(s_axi_rdata))
		else $error("read data dropped");
	a_frame_busy: assert property (rx_valid && rx_ready && rx_last |=> !rx_ready)
		else $error("frame taken while busy");
	a_tx_hold: assert property (tx_valid && !tx_ready |=> tx_valid && $stable(tx_data))
		else $error("result byte dropped");
	a_tx_excl: assert property (tx_valid |-> !rx_ready)
		else $error("frame taken before results");
	a_gpio_set: assert property (s_one(8'hF3) |-> ##[1:8] gpio_out[0])
		else $error("output not raised");
	a_gpio_clr: assert property (s_one(8'hFC) |-> ##[1:8] !gpio_out[4])
		else $error("output not lowered");
	a_version_out: assert property (s_one(8'hFE) |-> ##[1:8] tx_valid && tx_data == `RHCI_VERSION)
		else $error("version byte missing");
	a_ser_only: assert property (interface_select [*4] |-> !par_strobe && !par_oe)
		else $error("parallel activity in serial mode");
	a_par_only: assert property (!interface_select [*4] |-> !spi_sclk)
		else $error("serial clock in parallel mode");
endmodule // rhci_chk
bind rhci_top rhci_chk rhci_chk_inst (.aclk, .aresetn, .s_axi_awvalid, .s_axi_awready, .s_axi_wvalid,
	.s_axi_wready, .s_axi_bvalid, .s_axi_bready, .s_axi_arvalid, .s_axi_arready, .s_axi_rvalid,
	.s_axi_rready, .s_axi_rdata, .rx_valid, .rx_ready, .rx_data, .rx_last, .tx_valid, .tx_ready,
	.tx_data, .interface_select, .gpio_out, .spi_sclk, .par_oe, .par_strobe);
`default_nettype wire

// ---- bench/rhci_fe_model.sv ----
/*
 behavioural reader front-end: 32 registers behind serial or parallel link.
 assumes one select per register access; logs every byte written to it.
*/
`timescale 1ns/1ps
`default_nettype none
module rhci_fe_model (
	// select and serial link
	input wire logic		fe_sel_n,
	input wire logic		spi_sclk,
	input wire logic		spi_mosi,
	output logic			spi_miso,
	// parallel link
	input wire logic [7:0]	par_dout,
	output logic [7:0]		par_din,
	input wire logic		par_oe,
	input wire logic		par_strobe
);
	// *****
	// register file
	// *****
	logic [7:0]	regs [32];
	logic [7:0]	wq [$];
	logic [7:0]	sh, out, cnt;
	logic [4:0]	addr;
	logic		first, rd, cont, rdp;
	initial begin
		for (int i = 0; i < 32; i++) regs[i] = 8'h40 + 8'(i);
		spi_miso = 1'b0;
		par_din = 8'h00;
		first = 1'b1;
		rd = 1'b0;
		cont = 1'b0;
		out = 8'h00;
	end
	task automatic wbyte(input logic [7:0] b);
		wq.push_back(b);
		if (first) begin
			first = b[7];
			rd = b[6] && !b[7];
			cont = b[5];
			addr = b[4:0];
			out = regs[addr];
		end else if (!rd) begin
			regs[addr] = b;
			if (cont) addr++;
		end
	endtask
	task automatic rbyte;
		if (cont) addr++;
		out = regs[addr];
	endtask
	// *****
	// link sides
	// *****
	always @(negedge fe_sel_n) begin
		first = 1'b1;
		cnt = 8'h00;
	end
	always @(posedge fe_sel_n) begin
		spi_miso = ~spi_miso;
		par_din = ~par_din;
	end
	always @(posedge spi_sclk) if (!fe_sel_n) begin
		sh = {sh[6:0], spi_mosi};
		cnt++;
		if (cnt[2:0] == 3'h0) begin
			if (first || !rd) wbyte(sh);
			else rbyte();
		end
	end
	always @(negedge spi_sclk) if (!fe_sel_n) spi_miso = out[~cnt[2:0]];
	always @(posedge par_strobe) begin
		#1;
		rdp = !par_oe;
		if (par_oe) wbyte(par_dout);
		else par_din = out;
	end
	always @(negedge par_strobe) if (rdp) rbyte();
endmodule // rhci_fe_model
`default_nettype wire

// ---- bench/rhci_top_tb.sv ----
/*
 self-checking bench for the command interpreter top with a front-end model.
 assumes core/ on the include path; the checker is bound in separately.
*/
`timescale 1ns/1ps
`default_nettype none
`include "rhci_defs.vh"
module rhci_top_tb;
	logic			aclk, aresetn, s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready;
	logic			s_axi_bvalid, s_axi_bready, s_axi_arvalid, s_axi_arready, s_axi_rvalid, s_axi_rready;
	logic [5:0]		s_axi_awaddr, s_axi_araddr;
	logic [31:0]	s_axi_wdata, s_axi_rdata;
	logic [3:0]		s_axi_wstrb;
	logic [1:0]		s_axi_bresp, s_axi_rresp;
	logic			rx_valid, rx_ready, rx_last, tx_valid, tx_ready, interface_select;
	logic [7:0]		rx_data, tx_data, par_dout, par_din;
	logic [4:0]		gpio_out;
	logic			fe_sel_n, spi_sclk, spi_mosi, spi_miso, par_oe, par_strobe;
	logic [7:0]		txq [$];
	int				num_errors, n_tests, cyc;
	rhci_top rhci_top_inst (.aclk, .aresetn, .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready, .s_axi_wdata,
		.s_axi_wstrb, .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid, .s_axi_bready,
		.s_axi_araddr, .s_axi_arvalid, .s_axi_arready, .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid,
		.s_axi_rready, .rx_valid, .rx_ready, .rx_data, .rx_last, .tx_valid, .tx_ready, .tx_data,
		.interface_select, .gpio_out, .fe_sel_n, .spi_sclk, .spi_mosi, .spi_miso, .par_dout, .par_din,
		.par_oe, .par_strobe);
	rhci_fe_model rhci_fe_model_inst (.fe_sel_n, .spi_sclk, .spi_mosi, .spi_miso, .par_dout, .par_din,
		.par_oe, .par_strobe);
	initial aclk = 1'b0;
	always #4 aclk = ~aclk;
	// *****
	// shared tasks
	// *****
	task automatic complete_run;
		$display("comparisons %0d mismatches %0d", n_tests, num_errors);
		if (num_errors == 0 && n_tests > 0)
			$display("No errors found");
		else
			$display("Errors were found");
		$finish;
	endtask
	always @(posedge aclk) begin
		cyc++;
		if (cyc == 60000) begin
			num_errors++;
			complete_run();
		end
	end
	task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
		n_tests++;
		if (seen !== exp) begin
			num_errors++;
			$display("FAIL t=%0t seen=%h exp=%h", $time, seen, exp);
		end
	endtask
	task automatic axi_wr(input logic [5:0] a, input logic [31:0] d, output logic [1:0] r);
		@(posedge aclk);
		s_axi_awaddr <= a;
		s_axi_wdata <= d;
		s_axi_awvalid <= 1'b1;
		s_axi_wvalid <= 1'b1;
		s_axi_bready <= 1'b1;
		do begin
			@(posedge aclk);
			if (s_axi_awready) s_axi_awvalid <= 1'b0;
			if (s_axi_wready) s_axi_wvalid <= 1'b0;
		end while (!s_axi_bvalid);
		r = s_axi_bresp;
		s_axi_bready <= 1'b0;
	endtask
	task automatic axi_rd(input logic [5:0] a, output logic [31:0] d, output logic [1:0] r);
		@(posedge aclk);
		s_axi_araddr <= a;
		s_axi_arvalid <= 1'b1;
		s_axi_rready <= 1'b1;
		do begin
			@(posedge aclk);
			if (s_axi_arready) s_axi_arvalid <= 1'b0;
		end while (!s_axi_rvalid);
		d = s_axi_rdata;
		r = s_axi_rresp;
		s_axi_rready <= 1'b0;
	endtask
	task automatic cmd(input logic [255:0] f, input int n);
		txq.delete();
		@(posedge aclk);
		for (int i = n - 1; i >= 0; i--) begin
			rx_valid <= 1'b1;
			rx_data <= f[8*i +: 8];
			rx_last <= (i == 0);
			do @(posedge aclk); while (!rx_ready);
		end
		rx_valid <= 1'b0;
		do begin
			@(posedge aclk);
			if (tx_valid && tx_ready) txq.push_back(tx_data);
			tx_ready <= ~tx_ready;
		end while (!rx_ready);
	endtask
	task automatic fe_chk(input logic [255:0] e, input int n);
		chk(32'(rhci_fe_model_inst.wq.size()), 32'(n));
		for (int i = n - 1; i >= 0; i--) chk(rhci_fe_model_inst.wq.pop_front(), e[8*i +: 8]);
		rhci_fe_model_inst.wq.delete();
	endtask
	task automatic tx_chk(input logic [255:0] e, input int n);
		chk(32'(txq.size()), 32'(n));
		for (int i = n - 1; i >= 0; i--) chk(txq.pop_front(), e[8*i +: 8]);
	endtask
	task automatic proto(input logic [255:0] f, input int n, input logic [255:0] p, input int m);
		cmd(f, n);
		fe_chk(((256'h8F3D0000 | 256'(m)) << 8*(m+1)) | (p << 8) | 256'h91, m + 5);
		tx_chk(256'h0, 0);
	endtask
	// *****
	// scenarios
	// *****
	task automatic t_regs;
		logic [31:0]	d;
		logic [1:0]		r;
		axi_rd(`RHCI_ADDR_CTRL, d, r);
		chk(d, 32'h1);
		axi_rd(`RHCI_ADDR_STATUS, d, r);
		chk(d[1], 1'b1);
		axi_rd(`RHCI_ADDR_VERSION, d, r);
		chk(d[7:0], `RHCI_VERSION);
		axi_rd(6'h18, d, r);
		chk({d, r}, {32'h0, `RHCI_RESP_SLVERR});
		axi_wr(6'h1C, 32'h0, r);
		chk(r, `RHCI_RESP_SLVERR);
		axi_wr(`RHCI_ADDR_CTRL, 32'h0, r);
		@(negedge aclk);
		chk(rx_ready, 1'b0);
		axi_wr(`RHCI_ADDR_CTRL, 32'h1, r);
		chk(r, `RHCI_RESP_OKAY);
		cmd(256'h0F, 1);
		fe_chk(256'h0, 0);
		axi_rd(`RHCI_ADDR_ERRCNT, d, r);
		chk(d, 32'h1);
		$display("register test done");
	endtask
	task automatic t_access;
		cmd(256'h10E108, 3);
		fe_chk(256'h0108, 2);
		cmd(256'h1100215A, 4);
		fe_chk(256'h20215A, 3);
		cmd(256'h120100, 3);
		fe_chk(256'h4140, 2);
		tx_chk(256'h5A21, 2);
		cmd(256'h130302, 3);
		fe_chk(256'h62, 1);
		tx_chk(256'h424344, 3);
		cmd(256'h15FF, 2);
		fe_chk(256'h9F, 1);
		cmd(256'h168F3D, 3);
		fe_chk(256'h8F3D, 2);
		$display("access test done");
	endtask
	task automatic t_proto;
		proto(256'hA0, 1, 256'h26, 1);
		proto(256'hA1, 1, 256'h52, 1);
		proto(256'hB004, 2, 256'h050004, 3);
		proto(256'hB104, 2, 256'h05000C, 3);
		proto(256'h14060100, 4, 256'h060100, 3);
		proto(256'h18022033, 4, 256'h022033, 3);
		proto(256'h723011, 3, 256'h3011, 2);
		proto(256'h72A20411223344, 7, 256'hA20411223344, 6);
		proto(256'h723111, 3, 256'h3111, 2);
		proto(256'h72A105000102030405060708090A0B0C0D0E0F, 19, 256'hA105000102030405060708090A0B0C0D0E0F, 18);
		proto(256'hA293DE655D5ABC, 7, 256'h93DE655D5ABC, 6);
		$display("protocol test done");
	endtask
	task automatic t_gpio;
		logic [4:0] e;
		e = 5'h00;
		for (int c = 8'hF3; c <= 8'hFC; c++) begin
			cmd(256'(c), 1);
			e[(c - 8'hF3) >> 1] = c[0];
			chk(gpio_out, e);
		end
		cmd(256'hFE, 1);
		tx_chk(256'(`RHCI_VERSION), 1);
		$display("output test done");
	endtask
	task automatic t_par;
		logic [31:0]	d;
		logic [1:0]		r;
		@(posedge aclk);
		interface_select <= 1'b0;
		repeat (4) @(posedge aclk);
		axi_rd(`RHCI_ADDR_STATUS, d, r);
		chk(d[1], 1'b0);
		cmd(256'h1003C3, 3);
		fe_chk(256'h03C3, 2);
		cmd(256'h1203, 2);
		fe_chk(256'h43, 1);
		tx_chk(256'hC3, 1);
		interface_select <= 1'b1;
		repeat (4) @(posedge aclk);
		$display("parallel test done");
	endtask
	initial begin
		{aresetn, s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid, s_axi_rready} = '0;
		{s_axi_awaddr, s_axi_araddr, s_axi_wdata, rx_valid, rx_data, rx_last, tx_ready} = '0;
		s_axi_wstrb = 4'hF;
		interface_select = 1'b1;
		repeat (4) @(posedge aclk);
		aresetn <= 1'b1;
		repeat (3) @(posedge aclk);
		t_regs();
		t_access();
		t_proto();
		t_gpio();
		t_par();
		complete_run();
	end
endmodule // rhci_top_tb
`default_nettype wire

// ---- core/rhci_defs.vh ----
/*
 * constants of the host command interpreter: command codes, address word
 * bits, front-end sequence bytes, register map and timing.
 * assumes it is included by bare name from the core/ design files.
 */
`ifndef RHCI_DEFS_VH
`define RHCI_DEFS_VH

// ****************************************
// host command codes
// ****************************************
`define RHCI_CMD_WSINGLE   8'h10
`define RHCI_CMD_WCONT     8'h11
`define RHCI_CMD_RSINGLE   8'h12
`define RHCI_CMD_RCONT     8'h13
`define RHCI_CMD_INVENTORY 8'h14
`define RHCI_CMD_DIRECT    8'h15
`define RHCI_CMD_RAW       8'h16
`define RHCI_CMD_REQUEST   8'h18
`define RHCI_CMD_TAG       8'h72
`define RHCI_CMD_REQA      8'hA0
`define RHCI_CMD_WUPA      8'hA1
`define RHCI_CMD_SELECT    8'hA2
`define RHCI_CMD_REQB      8'hB0
`define RHCI_CMD_WUPB      8'hB1
`define RHCI_CMD_GPIO_LO   8'hF3
`define RHCI_CMD_GPIO_HI   8'hFC
`define RHCI_CMD_VERSION   8'hFE

// ****************************************
// tag sub-commands and their parameter counts
// ****************************************
`define RHCI_TAG_READ4     8'h30
`define RHCI_TAG_READ2     8'h31
`define RHCI_TAG_WRITE1    8'hA2
`define RHCI_TAG_WRITE2    8'hA1
`define RHCI_TAG_RD_NPAR   6'h02
`define RHCI_TAG_WR1_NPAR  6'h06
`define RHCI_TAG_WR2_NPAR  6'h12

// ****************************************
// address/command word
// ****************************************
`define RHCI_AW_CMD        8'h80
`define RHCI_AW_READ       8'h40
`define RHCI_AW_CONT       8'h20
`define RHCI_AW_MASK       8'h1F

// ****************************************
// front-end sequence bytes
// ****************************************
`define RHCI_FIFO_RESET    8'h8F
`define RHCI_TXLEN_ADDR    8'h1D
`define RHCI_DCMD_TX       8'h91
`define RHCI_REQA_CODE     8'h26
`define RHCI_WUPA_CODE     8'h52
`define RHCI_APF_B         8'h05
`define RHCI_AFI_ALL       8'h00
`define RHCI_WUPB_FLAG     8'h08
// arbitrary value
`define RHCI_VERSION       8'h01

// ****************************************
// sizes and timing
// ****************************************
`define RHCI_BUF_DEPTH     6'h20
`define RHCI_GPIO_W        5
`define RHCI_SCLK_DIV      8'h04

// ****************************************
// register map
// ****************************************
`define RHCI_ADDR_CTRL     6'h00
`define RHCI_ADDR_STATUS   6'h04
`define RHCI_ADDR_GPIO     6'h08
`define RHCI_ADDR_VERSION  6'h0C
`define RHCI_ADDR_CMDCNT   6'h10
`define RHCI_ADDR_ERRCNT   6'h14
`define RHCI_CTRL_RST      1'b1
`define RHCI_RESP_OKAY     2'b00
`define RHCI_RESP_SLVERR   2'b10

`endif

// ---- core/rhci_fe_link.v ----
/*
 * byte engine toward the reader front-end, serial or parallel.
 * assumes one op per byte; the select line rises after an op marked last.
 */
`timescale 1ns/1ps
`default_nettype none
`include "rhci_defs.vh"

module rhci_fe_link (
	// clock and reset
	input  wire       aclk,
	input  wire       aresetn,
	// mode: 1 serial, 0 parallel
	input  wire       spi_sel,
	// byte ops
	input  wire       op_valid,
	output wire       op_ready,
	input  wire [7:0] op_data,
	input  wire       op_read,
	input  wire       op_last,
	output reg        rd_valid,
	output reg  [7:0] rd_data,
	// front-end pins
	output reg        fe_sel_n,
	output reg        spi_sclk,
	output reg        spi_mosi,
	input  wire       spi_miso,
	output reg  [7:0] par_dout,
	input  wire [7:0] par_din,
	output reg        par_oe,
	output reg        par_strobe
);
	// ****************************************
	// state and synchronisers
	// ****************************************
	localparam L_IDLE = 3'b001;
	localparam L_XFER = 3'b010;
	localparam L_END  = 3'b100;

	reg [2:0] state;
	reg [7:0] div;
	reg       tick;
	reg       mode;
	reg       rd;
	reg       last;
	reg [7:0] sh;
	reg [7:0] rx;
	reg [2:0] bitc;
	reg       miso_m, miso_s;
	reg [7:0] pdin_m, pdin_s;

	assign op_ready = state[0];

	always @(posedge aclk) begin
		miso_m <= spi_miso;
		miso_s <= miso_m;
		pdin_m <= par_din;
		pdin_s <= pdin_m;
	end

	always @(posedge aclk) begin
		if (!aresetn) begin
			div  <= 8'h00;
			tick <= 1'b0;
		end else begin
			tick <= (div == `RHCI_SCLK_DIV - 8'h01);
			div  <= (div == `RHCI_SCLK_DIV - 8'h01) ? 8'h00 : div + 8'h01;
		end
	end

	// ****************************************
	// transfer
	// ****************************************
	always @(posedge aclk) begin
		if (!aresetn) begin
			state      <= L_IDLE;
			mode       <= 1'b1;
			rd         <= 1'b0;
			last       <= 1'b0;
			sh         <= 8'h00;
			rx         <= 8'h00;
			bitc       <= 3'h0;
			rd_valid   <= 1'b0;
			rd_data    <= 8'h00;
			fe_sel_n   <= 1'b1;
			spi_sclk   <= 1'b0;
			spi_mosi   <= 1'b0;
			par_dout   <= 8'h00;
			par_oe     <= 1'b0;
			par_strobe <= 1'b0;
		end else begin
			rd_valid <= 1'b0;
			case (state)
			L_IDLE: if (op_valid) begin
				mode     <= spi_sel;
				rd       <= op_read;
				last     <= op_last;
				sh       <= op_data;
				bitc     <= 3'h0;
				fe_sel_n <= 1'b0;
				spi_mosi <= spi_sel & op_data[7];
				par_dout <= op_data;
				par_oe   <= ~spi_sel & ~op_read;
				state    <= L_XFER;
			end
			L_XFER: if (tick) begin
				if (mode) begin
					spi_sclk <= ~spi_sclk;
					if (!spi_sclk)
						rx <= {rx[6:0], miso_s};
					else begin
						sh       <= {sh[6:0], 1'b0};
						spi_mosi <= sh[6];
						bitc     <= bitc + 3'h1;
						if (bitc == 3'h7)
							state <= L_END;
					end
				end else begin
					par_strobe <= ~par_strobe;
					if (par_strobe) begin
						rx    <= pdin_s;
						state <= L_END;
					end
				end
			end
			L_END: begin
				par_oe   <= 1'b0;
				spi_mosi <= 1'b0;
				rd_valid <= rd;
				rd_data  <= rx;
				if (last)
					fe_sel_n <= 1'b1;
				state <= L_IDLE;
			end
			default: state <= L_IDLE;
			endcase
		end
	end
endmodule // rhci_fe_link

`default_nettype wire

// ---- core/rhci_top.v ----
/*
 * host command interpreter: takes a command byte and its parameters, runs
 * them as address/command word sequences on the front-end, returns results.
 * assumes a frame parser upstream that strips framing and marks the last
 * byte; registers are reached over AXI4-Lite.
 */
// The register addresses and the AXI4-Lite interface to the registers were decided locally.
`timescale 1ns/1ps
`default_nettype none
`include "rhci_defs.vh"

// Summary of operation
// - 0x10 sends address pairs: address word with top three bits zero, then value.
// - 0x11 sends one continuous address word, then all values in turn.
// - 0x12 reads each listed register with the read bit set, returning each value.
// - 0x13 reads count registers upward from one read-continuous address word.
// - 0x15 sends the 5-bit direct command with the command bit set.
// - 0x16 forwards parameter bytes unchanged; host builds the words itself.
// - 0x14 sends a vicinity inventory request built from flags, command, mask length.
// - 0x18 sends a protocol request or halt; host issues it after setup.
// - tag 0x72 supports read four blocks 0x30 and write one block 0xA2.
// - tag 0x72 supports read two blocks 0x31 and write two blocks 0xA1.
// - 0xA0 and 0xA1 start type A anticollision with REQA or WUPA.
// - 0xA2 sends a type A SELECT with level code, identifier and check byte.
// - 0xB0 and 0xB1 start type B slotted anticollision with REQB or WUPB.
// - 0xF3 to 0xFC drive five outputs; odd sets high, even sets low.
// - 0xFE returns the version byte to the host.
// - a jumper selects serial or parallel front-end link for every access.
// - FIFO data moves only with continuous-address accesses.
module rhci_top (
	// clock and reset
	input  wire        aclk,
	input  wire        aresetn,
	// axi4-lite slave
	input  wire [5:0]  s_axi_awaddr,
	input  wire        s_axi_awvalid,
	output wire        s_axi_awready,
	input  wire [31:0] s_axi_wdata,
	input  wire [3:0]  s_axi_wstrb,
	input  wire        s_axi_wvalid,
	output wire        s_axi_wready,
	output reg  [1:0]  s_axi_bresp,
	output reg         s_axi_bvalid,
	input  wire        s_axi_bready,
	input  wire [5:0]  s_axi_araddr,
	input  wire        s_axi_arvalid,
	output wire        s_axi_arready,
	output reg  [31:0] s_axi_rdata,
	output reg  [1:0]  s_axi_rresp,
	output reg         s_axi_rvalid,
	input  wire        s_axi_rready,
	// command bytes from the frame parser
	input  wire        rx_valid,
	output wire        rx_ready,
	input  wire [7:0]  rx_data,
	input  wire        rx_last,
	// result bytes to the host
	output wire        tx_valid,
	input  wire        tx_ready,
	output reg  [7:0]  tx_data,
	// jumper and outputs
	input  wire        interface_select,
	output reg  [4:0]  gpio_out,
	// front-end pins
	output wire        fe_sel_n,
	output wire        spi_sclk,
	output wire        spi_mosi,
	input  wire        spi_miso,
	output wire [7:0]  par_dout,
	input  wire [7:0]  par_din,
	output wire        par_oe,
	output wire        par_strobe
);
	// ****************************************
	// state
	// ****************************************
	localparam S_RECV   = 4'b0001;
	localparam S_EXEC   = 4'b0010;
	localparam S_RDWAIT = 4'b0100;
	localparam S_RESP   = 4'b1000;

	reg  [3:0]  state;
	reg  [7:0]  bufm [0:31];
	reg  [5:0]  n;
	reg  [7:0]  cmd;
	reg         first;
	reg  [8:0]  step;
	reg         ctrl_en;
	reg  [15:0] cmd_cnt;
	reg  [15:0] err_cnt;
	reg         sel_m, sel_s;
	wire        op_ready;
	wire        rd_valid;
	wire [7:0]  rd_data;
	wire [7:0]  gdiff = cmd - `RHCI_CMD_GPIO_LO;
	wire        is_gpio = (cmd >= `RHCI_CMD_GPIO_LO) && (cmd <= `RHCI_CMD_GPIO_HI);
	wire        is_ver = (cmd == `RHCI_CMD_VERSION) && (step == 9'h000);

	// jumper passes two flops before use
	always @(posedge aclk) begin
		sel_m <= interface_select;
		sel_s <= sel_m;
	end

	// ****************************************
	// step generator
	// ****************************************
	reg        g_done, g_read, g_last, g_bad, proto;
	reg  [7:0] g_data, pf0, pf1, pf2, pk;
	reg  [1:0] pc;
	reg  [5:0] pn;
	reg  [8:0] plen, k;
	wire [7:0] b_i = bufm[step[4:0]];
	wire [7:0] b_h = bufm[step[5:1]];
	wire [7:0] b0 = bufm[0];
	wire [7:0] b1 = bufm[1];
	wire [8:0] nx = {3'h0, n};
	wire [8:0] nm1 = nx - 9'h001;

	always @* begin
		g_done = 1'b1;
		g_read = 1'b0;
		g_last = 1'b0;
		g_bad = 1'b0;
		g_data = 8'h00;
		proto = 1'b0;
		pc = 2'h0;
		pn = n;
		pf0 = 8'h00;
		pf1 = 8'h00;
		pf2 = 8'h00;
		case (cmd)
		`RHCI_CMD_WSINGLE: begin
			g_done = step >= {3'h0, n[5:1], 1'b0};
			g_data = step[0] ? b_i : (b_i & `RHCI_AW_MASK);
			g_last = step[0];
		end
		`RHCI_CMD_WCONT: begin
			g_done = (n < 6'h02) || (step >= nx);
			g_data = (step == 9'h000) ? ((b_i & `RHCI_AW_MASK) | `RHCI_AW_CONT) : b_i;
			g_last = step == nm1;
		end
		`RHCI_CMD_RSINGLE: begin
			g_done = step >= {2'h0, n, 1'b0};
			g_data = (b_h & `RHCI_AW_MASK) | `RHCI_AW_READ;
			g_read = step[0];
			g_last = step[0];
		end
		`RHCI_CMD_RCONT: begin
			g_done = (n < 6'h02) || (b0 == 8'h00) || (step > {1'b0, b0});
			g_data = (step == 9'h000) ? ((b1 & `RHCI_AW_MASK) | `RHCI_AW_READ | `RHCI_AW_CONT) : 8'h00;
			g_read = step != 9'h000;
			g_last = step == {1'b0, b0};
		end
		`RHCI_CMD_DIRECT: begin
			g_done = (n == 6'h00) || (step != 9'h000);
			g_data = (b0 & `RHCI_AW_MASK) | `RHCI_AW_CMD;
			g_last = 1'b1;
		end
		`RHCI_CMD_RAW: begin
			g_done = step >= nx;
			g_data = b_i;
			g_last = step == nm1;
		end
		`RHCI_CMD_INVENTORY: proto = 1'b1;
		`RHCI_CMD_REQUEST: proto = 1'b1;
		`RHCI_CMD_SELECT: proto = 1'b1;
		`RHCI_CMD_TAG: begin
			proto = 1'b1;
			g_bad = !((((b0 == `RHCI_TAG_READ4) || (b0 == `RHCI_TAG_READ2)) && (n == `RHCI_TAG_RD_NPAR))
				|| ((b0 == `RHCI_TAG_WRITE1) && (n == `RHCI_TAG_WR1_NPAR))
				|| ((b0 == `RHCI_TAG_WRITE2) && (n == `RHCI_TAG_WR2_NPAR)));
		end
		`RHCI_CMD_REQA, `RHCI_CMD_WUPA: begin
			proto = 1'b1;
			pc = 2'h1;
			pn = 6'h00;
			pf0 = cmd[0] ? `RHCI_WUPA_CODE : `RHCI_REQA_CODE;
		end
		`RHCI_CMD_REQB, `RHCI_CMD_WUPB: begin
			proto = 1'b1;
			pc = 2'h3;
			pn = 6'h00;
			pf0 = `RHCI_APF_B;
			pf1 = `RHCI_AFI_ALL;
			pf2 = cmd[0] ? (b0 | `RHCI_WUPB_FLAG) : b0;
			g_bad = n == 6'h00;
		end
		default: g_bad = !is_gpio && (cmd != `RHCI_CMD_VERSION);
		endcase
		plen = {7'h00, pc} + {3'h0, pn};
		k = step - 9'h004;
		case (k[1:0])
		2'h0: pk = pf0;
		2'h1: pk = pf1;
		default: pk = pf2;
		endcase
		if (proto && !g_bad) begin
			g_done = step > plen + 9'h004;
			g_last = (step == 9'h000) || (step >= plen + 9'h003);
			if (step == 9'h000)
				g_data = `RHCI_FIFO_RESET;
			else if (step == 9'h001)
				g_data = `RHCI_TXLEN_ADDR | `RHCI_AW_CONT;
			else if (step == 9'h002)
				g_data = 8'h00;
			else if (step == 9'h003)
				g_data = plen[7:0];
			else if (step == plen + 9'h004)
				g_data = `RHCI_DCMD_TX;
			else if (k < {7'h00, pc})
				g_data = pk;
			else
				g_data = bufm[k[4:0] - {3'h0, pc}];
		end
	end

	// ****************************************
	// command sequencer
	// ****************************************
	assign rx_ready = state[0] & ctrl_en;
	assign tx_valid = state[3];

	always @(posedge aclk) begin
		if (rx_valid && rx_ready && !first && (n < `RHCI_BUF_DEPTH))
			bufm[n[4:0]] <= rx_data;
	end

	always @(posedge aclk) begin
		if (!aresetn) begin
			state <= S_RECV;
			n <= 6'h00;
			cmd <= 8'h00;
			first <= 1'b1;
			step <= 9'h000;
			tx_data <= 8'h00;
			gpio_out <= 5'h00;
			cmd_cnt <= 16'h0000;
			err_cnt <= 16'h0000;
		end else begin
			case (state)
			S_RECV: if (rx_valid && rx_ready) begin
				if (first) begin
					cmd <= rx_data;
					first <= 1'b0;
				end else if (n < `RHCI_BUF_DEPTH)
					n <= n + 6'h01;
				if (rx_last) begin
					step <= 9'h000;
					state <= S_EXEC;
				end
			end
			S_EXEC: if (is_ver) begin
				tx_data <= `RHCI_VERSION;
				state <= S_RESP;
			end else if (g_done && op_ready) begin
				if (is_gpio)
					gpio_out[gdiff[3:1]] <= cmd[0];
				if (g_bad)
					err_cnt <= err_cnt + 16'h0001;
				cmd_cnt <= cmd_cnt + 16'h0001;
				n <= 6'h00;
				first <= 1'b1;
				state <= S_RECV;
			end else if (op_ready) begin
				step <= step + 9'h001;
				if (g_read)
					state <= S_RDWAIT;
			end
			S_RDWAIT: if (rd_valid) begin
				tx_data <= rd_data;
				state <= S_RESP;
			end
			S_RESP: if (tx_ready) begin
				if (is_ver)
					step <= 9'h001;
				state <= S_EXEC;
			end
			default: state <= S_RECV;
			endcase
		end
	end

	rhci_fe_link rhci_fe_link_inst (
		.aclk       (aclk),
		.aresetn    (aresetn),
		.spi_sel    (sel_s),
		.op_valid   (state[1] & ~g_done & ~is_ver),
		.op_ready   (op_ready),
		.op_data    (g_data),
		.op_read    (g_read),
		.op_last    (g_last),
		.rd_valid   (rd_valid),
		.rd_data    (rd_data),
		.fe_sel_n   (fe_sel_n),
		.spi_sclk   (spi_sclk),
		.spi_mosi   (spi_mosi),
		.spi_miso   (spi_miso),
		.par_dout   (par_dout),
		.par_din    (par_din),
		.par_oe     (par_oe),
		.par_strobe (par_strobe)
	);

	// ****************************************
	// register slave
	// ****************************************
	reg        aw_hold, w_hold;
	reg [5:0]  aw_addr;
	reg [31:0] w_data;
	reg [3:0]  w_strb;

	assign s_axi_awready = ~aw_hold & ~s_axi_bvalid;
	assign s_axi_wready  = ~w_hold & ~s_axi_bvalid;
	assign s_axi_arready = ~s_axi_rvalid;

	always @(posedge aclk) begin
		if (!aresetn) begin
			aw_hold <= 1'b0;
			w_hold <= 1'b0;
			aw_addr <= 6'h00;
			w_data <= 32'h00000000;
			w_strb <= 4'h0;
			ctrl_en <= `RHCI_CTRL_RST;
			s_axi_bvalid <= 1'b0;
			s_axi_bresp <= `RHCI_RESP_OKAY;
			s_axi_rvalid <= 1'b0;
			s_axi_rresp <= `RHCI_RESP_OKAY;
			s_axi_rdata <= 32'h00000000;
		end else begin
			if (s_axi_awvalid && s_axi_awready) begin
				aw_hold <= 1'b1;
				aw_addr <= s_axi_awaddr;
			end
			if (s_axi_wvalid && s_axi_wready) begin
				w_hold <= 1'b1;
				w_data <= s_axi_wdata;
				w_strb <= s_axi_wstrb;
			end
			if (aw_hold && w_hold && !s_axi_bvalid) begin
				aw_hold <= 1'b0;
				w_hold <= 1'b0;
				s_axi_bvalid <= 1'b1;
				s_axi_bresp <= (aw_addr[5:2] > `RHCI_ADDR_ERRCNT >> 2) ? `RHCI_RESP_SLVERR : `RHCI_RESP_OKAY;
				if ((aw_addr[5:2] == `RHCI_ADDR_CTRL >> 2) && w_strb[0])
					ctrl_en <= w_data[0];
			end else if (s_axi_bvalid && s_axi_bready)
				s_axi_bvalid <= 1'b0;
			if (s_axi_arvalid && s_axi_arready) begin
				s_axi_rvalid <= 1'b1;
				s_axi_rresp <= `RHCI_RESP_OKAY;
				case ({s_axi_araddr[5:2], 2'b00})
				`RHCI_ADDR_CTRL:    s_axi_rdata <= {31'h00000000, ctrl_en};
				`RHCI_ADDR_STATUS:  s_axi_rdata <= {16'h0000, cmd, 6'h00, sel_s, ~state[0]};
				`RHCI_ADDR_GPIO:    s_axi_rdata <= {27'h0000000, gpio_out};
				`RHCI_ADDR_VERSION: s_axi_rdata <= {24'h000000, `RHCI_VERSION};
				`RHCI_ADDR_CMDCNT:  s_axi_rdata <= {16'h0000, cmd_cnt};
				`RHCI_ADDR_ERRCNT:  s_axi_rdata <= {16'h0000, err_cnt};
				default: begin
					s_axi_rdata <= 32'h00000000;
					s_axi_rresp <= `RHCI_RESP_SLVERR;
				end
				endcase
			end else if (s_axi_rvalid && s_axi_rready)
				s_axi_rvalid <= 1'b0;
		end
	end
endmodule // rhci_top

`default_nettype wire
